// ### src/gpio_port.v
`timescale 1ns/1ps
`include "gpio_port_regs.vh"
module gpio_port #(
    parameter WIDTH = 6 // port pins
) (
    input wire clk_in, // instruction-cycle clock
    input wire reset_n_in, // async reset, active low
    input wire wake_reset_in, // last reset came from pin change
    input wire power_on_in, // last reset was power-on
    input wire [7:0] work_reg_in, // working register value
    input wire dir_load_in, // direction-load instruction strobe
    input wire option_load_in, // option-load instruction strobe
    input wire [7:0] addr_in, // file register address
    input wire wr_in, // file write strobe
    input wire [7:0] wdata_in, // file write data
    input wire bit_set_instr_in, // bit set instruction strobe
    input wire bit_clear_instr_in, // bit clear instruction strobe
    input wire [2:0] bit_sel_in, // bit select for set/clear
    input wire [WIDTH-1:0] alt_func_in, // pins given to alternate use
    input wire eeprom_variant_in, // serial lines present
    input wire serial_clk_in, // serial clock line level
    input wire serial_data_in, // serial data line level
    input wire [WIDTH-1:0] pin_in, // pin levels
    output reg [WIDTH-1:0] pin_out, // pin output values
    output reg [WIDTH-1:0] pin_oe_out, // pin output enables
    output reg [7:0] rdata_out, // file read data
    output reg wake_on_change_flag_out, // status bit 7
    output reg [WIDTH-1:0] pullup_en_out, // weak pull-up enables
    output reg [WIDTH-1:0] wake_en_out, // wake-on-change enables
    output reg timer_clock_source_sel_out // timer source select
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    reg [WIDTH-1:0] port_direction;
    reg [7:0] option_config;
    reg [WIDTH-1:0] out_latch;
    reg [1:0] serial_bits;
    wire [WIDTH-1:0] pin_sync_lvl;
    wire serial_clk_lvl;
    wire serial_data_lvl;
    reg [WIDTH-1:0] pin_read;
    reg [WIDTH-1:0] next_direction;
    reg [7:0] next_option;
    reg [WIDTH-1:0] next_latch;
    reg [1:0] next_serial;
    reg [WIDTH-1:0] next_oe;
    reg [7:0] next_rdata;
    reg [7:0] rmw_val;
    reg [WIDTH-1:0] next_pullup;
    reg [WIDTH-1:0] next_wake_en;
    reg next_wake_flag;
    wire port_sel;
    wire status_sel;
    wire rmw_op;
    wire port_write;

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    // set/clear on the port outranks a plain write in the same cycle
    assign port_sel = (addr_in == `PORT_DATA_ADDR);
    assign status_sel = (addr_in == `STATUS_FLAGS_ADDR);
    assign rmw_op = port_sel & (bit_set_instr_in | bit_clear_instr_in);
    assign port_write = port_sel & wr_in & ~rmw_op;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    // pins change at any time; two stages before any logic reads them
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : sync_gen
            pin_sync u_sync (
                .clk_in(clk_in),
                .reset_n_in(reset_n_in),
                .pin_in(pin_in[g]),
                .level_out(pin_sync_lvl[g])
            );
        end
    endgenerate

    // serial lines are pins as well, so they get the same treatment
    pin_sync u_sync_serial_clk (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .pin_in(serial_clk_in),
        .level_out(serial_clk_lvl)
    );

    // data line of the serial pair
    pin_sync u_sync_serial_data (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .pin_in(serial_data_in),
        .level_out(serial_data_lvl)
    );

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    // live pin levels, never the latch; alternate pins read as zero
    always @* begin
        pin_read = pin_sync_lvl & ~alt_func_in;
    end

    // read mux; unused addresses read zero
    always @* begin
        next_rdata = 8'h00;
        if (port_sel) begin
            next_rdata[WIDTH-1:0] = pin_read;
            // without the serial lines the top bits read zero
            if (eeprom_variant_in) begin
                next_rdata[7] = serial_clk_lvl;
                next_rdata[6] = serial_data_lvl;
            end
        end else if (status_sel) begin
            next_rdata[`WAKE_FLAG_BIT] = wake_on_change_flag_out;
        end
    end

    // ---------------------------------------------------------------
    // read-modify-write
    // ---------------------------------------------------------------
    // pins 5:0 are re-read (bits 7:6 reuse the latch), so inputs copy their level into latch;
    // a user must expect input pins to overwrite their stored value
    always @* begin
        rmw_val = {serial_bits, pin_read};
        if (bit_set_instr_in) begin
            rmw_val[bit_sel_in] = 1'b1;
        end
        // clear is applied last, so it wins if both strobes are high
        if (bit_clear_instr_in) begin
            rmw_val[bit_sel_in] = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // output latch next value
    // ---------------------------------------------------------------
    // latch holds unless the port is written, whatever the direction
    always @* begin
        next_latch = out_latch;
        next_serial = serial_bits;
        if (rmw_op) begin
            next_latch = rmw_val[WIDTH-1:0];
            next_serial = rmw_val[7:6];
        end else if (port_write) begin
            next_latch = wdata_in[WIDTH-1:0];
            next_serial = wdata_in[7:6];
        end
    end

    // ---------------------------------------------------------------
    // direction and option next values
    // ---------------------------------------------------------------
    // only the load strobe changes direction; bits 7:6 are dropped
    always @* begin
        next_direction = port_direction;
        if (dir_load_in) begin
            next_direction = work_reg_in[WIDTH-1:0];
        end
    end

    // option register is loaded whole from the working register
    always @* begin
        next_option = option_config;
        if (option_load_in) begin
            next_option = work_reg_in;
        end
    end

    // ---------------------------------------------------------------
    // output enables
    // ---------------------------------------------------------------
    // built from next values so a load shows at the same closing edge
    // as a port write does
    always @* begin
        next_oe = ~next_direction;
        next_oe[`INPUT_ONLY_PIN] = 1'b0;
        // external timer clock takes the shared pin as an input
        if (next_option[`OPT_TMR_SRC_BIT]) begin
            next_oe[`TIMER_SHARED_PIN] = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // group enables for pull-ups and wake-on-change
    // ---------------------------------------------------------------
    // one option bit each; no per-pin choice exists
    always @* begin
        next_pullup = {WIDTH{1'b0}};
        next_wake_en = {WIDTH{1'b0}};
        if (!next_option[`OPT_PULLUP_DIS_BIT]) begin
            next_pullup = `PULLUP_PIN_MASK;
        end
        if (!next_option[`OPT_WAKE_DIS_BIT]) begin
            next_wake_en = `PULLUP_PIN_MASK;
        end
    end

    // power-on always clears the wake cause
    always @* begin
        next_wake_flag = wake_reset_in & ~power_on_in;
    end

    // ---------------------------------------------------------------
    // direction, option and serial bits
    // ---------------------------------------------------------------
    // every reset disables all drivers; direction cannot be read back
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            port_direction <= `DIR_RESET;
            option_config <= `OPTION_RESET;
            serial_bits <= `SERIAL_BITS_RESET;
        end else begin
            port_direction <= next_direction;
            option_config <= next_option;
            serial_bits <= next_serial;
        end
    end

    // ---------------------------------------------------------------
    // output data latch
    // ---------------------------------------------------------------
    // no async reset on purpose: only power-on clears it, on the clock
    // edges seen during reset; any other reset leaves it untouched
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            if (power_on_in) begin
                out_latch <= {WIDTH{1'b0}};
            end
        end else begin
            out_latch <= next_latch;
        end
    end

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    // driven value tracks the latch, so a wake reset keeps it too;
    // enables are off during reset, so nothing reaches the pins
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            pin_out <= power_on_in ? {WIDTH{1'b0}} : out_latch;
        end else begin
            pin_out <= next_latch;
        end
    end

    // enables drop at once on reset so nothing is driven
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_oe_out <= {WIDTH{1'b0}};
        end else begin
            pin_oe_out <= next_oe;
        end
    end

    // read data reflects pins sampled the edge before the reading cycle opens
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= next_rdata;
        end
    end

    // wake cause flag, rebuilt from the reset cause every cycle
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wake_on_change_flag_out <= 1'b0;
        end else begin
            wake_on_change_flag_out <= next_wake_flag;
        end
    end

    // group pull-up enables
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pullup_en_out <= {WIDTH{1'b0}};
        end else begin
            pullup_en_out <= next_pullup;
        end
    end

    // group wake-on-change enables
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wake_en_out <= {WIDTH{1'b0}};
        end else begin
            wake_en_out <= next_wake_en;
        end
    end

    // timer source select mirrors option bit 5, set after reset
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            timer_clock_source_sel_out <= 1'b1;
        end else begin
            timer_clock_source_sel_out <= next_option[`OPT_TMR_SRC_BIT];
        end
    end
endmodule // gpio_port

// ### src/gpio_port_regs.vh
`ifndef GPIO_PORT_REGS_VH
`define GPIO_PORT_REGS_VH
// ---------------------------------------------------------------
// register addresses and layouts
// ---------------------------------------------------------------
`define STATUS_FLAGS_ADDR 8'h03
`define PORT_DATA_ADDR 8'h06
`define WAKE_FLAG_BIT 7
`define DIR_RESET 6'h3f
`define OPTION_RESET 8'hff
`define OPT_WAKE_DIS_BIT 7
`define OPT_PULLUP_DIS_BIT 6
`define OPT_TMR_SRC_BIT 5
`define INPUT_ONLY_PIN 3
`define TIMER_SHARED_PIN 2
`define SERIAL_BITS_RESET 2'h3
`define PULLUP_PIN_MASK 6'h0b
`endif

// ### src/pin_sync.v
`timescale 1ns/1ps
// two-stage synchroniser for one pin level
module pin_sync (
    input wire clk_in, // clock
    input wire reset_n_in, // async reset, active low
    input wire pin_in, // raw pin level
    output reg level_out // synchronised level
);
    reg meta;
    // ---------------------------------------------------------------
    // first stage feeds only the second
    // ---------------------------------------------------------------
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta <= 1'b0;
            level_out <= 1'b0;
        end else begin
            meta <= pin_in;
            level_out <= meta;
        end
    end
endmodule // pin_sync

// ### test/gpio_port_properties.sv
`timescale 1ns/1ps
module gpio_port_properties #(parameter WIDTH = 6) (
    input wire clk_in, // clock
    input wire reset_n_in, // reset
    input wire wake_reset_in, // wake cause
    input wire power_on_in, // por
    input wire [7:0] work_reg_in, // w
    input wire dir_load_in, // dir load
    input wire [7:0] addr_in, // addr
    input wire wr_in, // write
    input wire [7:0] wdata_in, // data
    input wire bit_set_instr_in, // set
    input wire bit_clear_instr_in, // clear
    input wire [2:0] bit_sel_in, // bit
    input wire [WIDTH-1:0] alt_func_in, // alt
    input wire [WIDTH-1:0] pin_in, // pins
    input wire [WIDTH-1:0] pin_out, // latch
    input wire [WIDTH-1:0] pin_oe_out, // oe
    input wire [7:0] rdata_out, // read
    input wire wake_on_change_flag_out // flag
);
default clocking @(posedge clk_in); endclocking
default disable iff (!reset_n_in);
// port decode; set/clear win over plain writes
wire psel = addr_in == 8'h06;
wire rmw = psel & (bit_set_instr_in | bit_clear_instr_in);
input_only_off_a: assert property (!pin_oe_out[3])
    else $error("input pin driven");
dir_load_a: assert property (dir_load_in |=>
    (pin_oe_out & 6'h33) == (6'h33 & ~$past(work_reg_in))) else $error("dir");
latch_write_a: assert property (wr_in && psel && !rmw |=>
    ((pin_out ^ $past(wdata_in)) & 8'h3f) == 0) else $error("write");
latch_hold_a: assert property (!wr_in && !rmw |=> $stable(pin_out))
    else $error("latch moved");
bit_set_a: assert property (rmw && !bit_clear_instr_in && bit_sel_in < 6
    |=> pin_out[$past(bit_sel_in)]) else $error("set");
bit_clear_a: assert property (rmw && bit_clear_instr_in && bit_sel_in < 6
    |=> !pin_out[$past(bit_sel_in)]) else $error("clear");
wake_flag_a: assert property (1 |=> wake_on_change_flag_out ==
    ($past(wake_reset_in) & ~$past(power_on_in))) else $error("flag");
// two sync stages plus the read register need three quiet samples; the check takes four
pin_read_a: assert property ((psel && alt_func_in == 0
    && $stable(pin_in)) [*4] |-> rdata_out[5:0] == pin_in) else $error("read");
alt_zero_a: assert property (psel |=>
    (rdata_out[5:0] & $past(alt_func_in)) == 0) else $error("alt");
cover property (dir_load_in);
cover property (rmw);
cover property (wake_on_change_flag_out);
endmodule // gpio_port_properties

// ### test/gpio_port_tb.sv
`timescale 1ns/1ps
module gpio_port_tb;
logic clk_in = 0, reset_n_in = 0, wake_reset_in = 0, power_on_in = 1;
logic dir_load_in = 0, option_load_in = 0, wr_in = 0, bit_set_instr_in = 0;
logic bit_clear_instr_in = 0, eeprom_variant_in = 0, serial_clk_in = 0;
logic serial_data_in = 0, wake_on_change_flag_out, timer_clock_source_sel_out;
logic [7:0] work_reg_in = 0, addr_in = 8'h06, wdata_in = 0, rdata_out;
logic [2:0] bit_sel_in = 0;
logic [5:0] alt_func_in = 0, ext_val = 0, pin_in, pin_out, pin_oe_out;
logic [5:0] pullup_en_out, wake_en_out;
int n_fail = 0, tests_run = 0, lat = 0, dir = 63, opt = 255;
always #25 clk_in = ~clk_in;
gpio_port #(.WIDTH(6)) u_dut (.*);
pin_load_model u_ext (.drv_in(pin_out), .oe_in(pin_oe_out),
    .ext_in(ext_val), .pin_out(pin_in));
// bench model of enables and pin levels
function logic [5:0] oe_x();
    oe_x = ~dir[5:0] & 6'h37 & (opt[5] ? 6'h3b : 6'h3f);
endfunction
function logic [5:0] lvl();
    lvl = (oe_x() & lat[5:0]) | (~oe_x() & ext_val);
endfunction
task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
        n_fail++;
        $display("BAD %0t got %h exp %h", $time, got, exp);
    end
endtask
task cyc(input int n);
    repeat (n) @(negedge clk_in);
endtask
task automatic op(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
endtask
task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
endtask
// random directions, latch writes, reads and read-modify-writes
initial begin
    lat = $urandom(99593);
    lat = 0;
    cyc(4);
    reset_n_in = 1;
    cyc(1);
    chk(pin_oe_out, 0);
    chk(wake_on_change_flag_out, 0);
    for (int i = 0; i < 8; i++) begin
        work_reg_in = $urandom;
        dir = work_reg_in[5:0];
        op(dir_load_in);
        wdata_in = $urandom;
        lat = wdata_in[5:0];
        op(wr_in);
        chk(pin_oe_out, oe_x());
        chk(pin_out, lat);
    end
    $display("direction and write test done");
    work_reg_in = 8'h1f;
    opt = 8'h1f;
    op(option_load_in);
    chk(pin_oe_out, oe_x());
    chk(pullup_en_out, 6'h0b);
    chk(wake_en_out, 6'h0b);
    chk(timer_clock_source_sel_out, 0);
    $display("option test done");
    for (int i = 0; i < 8; i++) begin
        ext_val = $urandom;
        alt_func_in = (i < 4) ? 6'h00 : 6'($urandom);
        eeprom_variant_in = i[0];
        {serial_clk_in, serial_data_in} = 2'($urandom);
        cyc(4);
        chk(rdata_out, {eeprom_variant_in ? {serial_clk_in, serial_data_in}
            : 2'b00, lvl() & ~alt_func_in});
        if (i < 4) begin
            bit_sel_in = 3'($urandom % 6);
            lat = lvl();
            lat[bit_sel_in] = i[1];
            if (i[1]) op(bit_set_instr_in);
            else op(bit_clear_instr_in);
            cyc(1); // gap before the next read
            chk(pin_out, lat);
        end
    end
    $display("read and modify test done");
    reset_n_in = 0;
    wake_reset_in = 1;
    power_on_in = 0;
    cyc(4);
    reset_n_in = 1;
    cyc(2);
    chk(wake_on_change_flag_out, 1);
    chk(pin_oe_out, 0);
    chk(timer_clock_source_sel_out, 1);
    chk(pin_out, lat);
    addr_in = 8'h03;
    cyc(1);
    chk(rdata_out, 8'h80);
    $display("wake reset test done");
    end_sim();
end
endmodule // gpio_port_tb
bind gpio_port gpio_port_properties #(.WIDTH(WIDTH)) u_props (.*);

// ### test/pin_load_model.sv
`timescale 1ns/1ps
module pin_load_model (
    input wire [5:0] drv_in, // device values
    input wire [5:0] oe_in, // device enables
    input wire [5:0] ext_in, // outside level
    output logic [5:0] pin_out // pin levels
);
// device wins where enabled; outside circuit holds the rest
assign pin_out = (oe_in & drv_in) | (~oe_in & ext_in);
endmodule // pin_load_model
